// [iacl_matcher.sv]
// IPv4 access control entry matcher with plain register port
// Functional notes
// - IPv4 criteria apply only when the entry's frame type is IPv4.
// - Specific protocol hits only frames with equal 8-bit protocol number.
// - ICMP, UDP or TCP choice restricts protocol and enables its extra criteria.
// - TTL zero excludes TTL above zero; non-zero needs TTL above zero.
// - Fragmented means MF set or offset above zero; No excludes, Yes requires.
// - Options No excludes flagged frames; Yes requires the options flag.
// - Source host mode needs exact source address equality.
// - Source network mode compares only masked source bits.
// - Destination host mode needs exact destination address equality.
// - Destination network mode compares only masked destination bits.
// - Specific ICMP type hits only ICMP frames with equal type.
// - Specific ICMP code hits only ICMP frames with equal code.
//
// The strobed register port and the placing of the registers were left to the implementer.
module iacl_matcher
    import iacl_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [3:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    input wire logic i_frame_valid,
    input wire iacl_frame_t i_frame,
    output logic o_result_valid,
    output iacl_result_t o_result
);

    // ==========================================================
    // Decoding helpers
    // Address compare, host exact or network masked
    function automatic logic addr_ok(input logic [1:0] sel, input logic [31:0] got,
                                     input logic [31:0] want, input logic [31:0] mask);
        logic ok;
        ok = 1'b1;
        unique case (sel)
            IACL_AD_ANY: ok = 1'b1;
            IACL_AD_HOST: ok = (got == want);
            IACL_AD_NET: ok = ((got & mask) == (want & mask));
            default: ok = 1'b1;
        endcase
        return ok;
    endfunction

    // Three-way flag compare
    function automatic logic tri_ok(input logic [1:0] sel, input logic flag);
        logic ok;
        ok = 1'b1;
        unique case (sel)
            IACL_TRI_ANY: ok = 1'b1;
            IACL_TRI_NO: ok = !flag;
            IACL_TRI_YES: ok = flag;
            default: ok = 1'b1;
        endcase
        return ok;
    endfunction

    // ==========================================================
    // Configuration registers
    logic [IACL_CTRL_USED-1:0] ctrl_q, ctrl_d;
    logic [31:0] vals_q, vals_d;
    logic [31:0] src_addr_q, src_addr_d;
    logic [31:0] src_mask_q, src_mask_d;
    logic [31:0] dst_addr_q, dst_addr_d;
    logic [31:0] dst_mask_q, dst_mask_d;
    logic [31:0] rdata_q, rdata_d;
    logic [15:0] hit_cnt_q, hit_cnt_d;
    logic last_hit_q, last_hit_d;
    logic res_valid_q, res_valid_d;
    iacl_result_t res_q, res_d;

    // Decoded setting fields
    logic [1:0] ftype_sel;
    logic [2:0] proto_sel;
    logic [1:0] ttl_sel, frag_sel, opt_sel, src_sel, dst_sel;
    logic itype_spec, icode_spec;
    logic [7:0] proto_val, itype_val, icode_val;

    assign ftype_sel = ctrl_q[IACL_CTRL_FTYPE_LSB +: 2];
    assign proto_sel = ctrl_q[IACL_CTRL_PROTO_LSB +: 3];
    assign ttl_sel = ctrl_q[IACL_CTRL_TTL_LSB +: 2];
    assign frag_sel = ctrl_q[IACL_CTRL_FRAG_LSB +: 2];
    assign opt_sel = ctrl_q[IACL_CTRL_OPT_LSB +: 2];
    assign src_sel = ctrl_q[IACL_CTRL_SRC_LSB +: 2];
    assign dst_sel = ctrl_q[IACL_CTRL_DST_LSB +: 2];
    assign itype_spec = ctrl_q[IACL_CTRL_ITYPE_BIT];
    assign icode_spec = ctrl_q[IACL_CTRL_ICODE_BIT];
    assign proto_val = vals_q[IACL_VALS_PROTO_LSB +: 8];
    assign itype_val = vals_q[IACL_VALS_ITYPE_LSB +: 8];
    assign icode_val = vals_q[IACL_VALS_ICODE_LSB +: 8];

    // ==========================================================
    // Match evaluation
    logic ipv4_sel, proto_ok, ttl_ok, frag_ok, opt_ok, src_ok, dst_ok;
    logic icmp_on, icmp_ok, is_frag, l4_on, hit;

    // Per-criterion checks
    always_comb begin
        ipv4_sel = (ftype_sel == IACL_FT_IPV4);
        unique case (proto_sel)
            IACL_PR_SPECIFIC: proto_ok = (i_frame.protocol == proto_val);
            IACL_PR_ICMP: proto_ok = (i_frame.protocol == IACL_PROTO_ICMP);
            IACL_PR_UDP: proto_ok = (i_frame.protocol == IACL_PROTO_UDP);
            IACL_PR_TCP: proto_ok = (i_frame.protocol == IACL_PROTO_TCP);
            default: proto_ok = 1'b1;
        endcase
        l4_on = (proto_sel == IACL_PR_ICMP) || (proto_sel == IACL_PR_UDP)
                || (proto_sel == IACL_PR_TCP);
        ttl_ok = tri_ok(ttl_sel, (i_frame.ttl != 8'h00));
        is_frag = i_frame.more_frag || (i_frame.frag_offset != 13'h0000);
        frag_ok = tri_ok(frag_sel, is_frag);
        opt_ok = tri_ok(opt_sel, i_frame.options);
        src_ok = addr_ok(src_sel, i_frame.source_ipv4_address, src_addr_q, src_mask_q);
        dst_ok = addr_ok(dst_sel, i_frame.destination_ipv4_address, dst_addr_q,
                         dst_mask_q);
        // ICMP criteria only live under the ICMP protocol choice
        icmp_on = (proto_sel == IACL_PR_ICMP);
        icmp_ok = !icmp_on
                  || ((!itype_spec || (i_frame.icmp_type == itype_val))
                      && (!icode_spec || (i_frame.icmp_code == icode_val)));
        // Other frame types ignore every IPv4 criterion
        if (ipv4_sel) begin
            hit = i_frame.is_ipv4 && proto_ok && ttl_ok && frag_ok && opt_ok
                  && src_ok && dst_ok && icmp_ok;
        end else begin
            hit = 1'b1;
        end
    end

    // ==========================================================
    // Result and status next values
    always_comb begin
        res_valid_d = i_frame_valid;
        res_d = res_q;
        hit_cnt_d = hit_cnt_q;
        last_hit_d = last_hit_q;
        if (i_frame_valid) begin
            res_d.hit = hit;
            res_d.ipv4_selected = ipv4_sel;
            res_d.l4_enable = ipv4_sel && l4_on;
            last_hit_d = hit;
            if (hit) begin
                hit_cnt_d = hit_cnt_q + IACL_CNT_ONE;
            end
        end
        if (i_reg_wr && (i_reg_addr == IACL_REG_HIT_CNT)) begin
            hit_cnt_d = i_reg_wdata[15:0];
        end
    end

    // ==========================================================
    // Register write and read next values
    always_comb begin
        ctrl_d = ctrl_q;
        vals_d = vals_q;
        src_addr_d = src_addr_q;
        src_mask_d = src_mask_q;
        dst_addr_d = dst_addr_q;
        dst_mask_d = dst_mask_q;
        rdata_d = IACL_RST_WORD;
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                IACL_REG_CTRL: ctrl_d = i_reg_wdata[IACL_CTRL_USED-1:0];
                IACL_REG_VALS: vals_d = {8'h00, i_reg_wdata[23:0]};
                IACL_REG_SRC_ADDR: src_addr_d = i_reg_wdata;
                IACL_REG_SRC_MASK: src_mask_d = i_reg_wdata;
                IACL_REG_DST_ADDR: dst_addr_d = i_reg_wdata;
                IACL_REG_DST_MASK: dst_mask_d = i_reg_wdata;
                default: ctrl_d = ctrl_q;
            endcase
        end
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                IACL_REG_CTRL: rdata_d = {{(32-IACL_CTRL_USED){1'b0}}, ctrl_q};
                IACL_REG_VALS: rdata_d = vals_q;
                IACL_REG_SRC_ADDR: rdata_d = src_addr_q;
                IACL_REG_SRC_MASK: rdata_d = src_mask_q;
                IACL_REG_DST_ADDR: rdata_d = dst_addr_q;
                IACL_REG_DST_MASK: rdata_d = dst_mask_q;
                IACL_REG_STATUS: rdata_d = {29'h0000_0000, ipv4_sel && l4_on,
                                            ipv4_sel, last_hit_q};
                IACL_REG_HIT_CNT: rdata_d = {16'h0000, hit_cnt_q};
                default: rdata_d = IACL_RST_WORD;
            endcase
        end
    end

    // ==========================================================
    // State registers
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            ctrl_q <= '0;
            vals_q <= IACL_RST_WORD;
            src_addr_q <= IACL_RST_WORD;
            src_mask_q <= IACL_RST_WORD;
            dst_addr_q <= IACL_RST_WORD;
            dst_mask_q <= IACL_RST_WORD;
            rdata_q <= IACL_RST_WORD;
            hit_cnt_q <= 16'h0000;
            last_hit_q <= 1'b0;
            res_valid_q <= 1'b0;
            res_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            vals_q <= vals_d;
            src_addr_q <= src_addr_d;
            src_mask_q <= src_mask_d;
            dst_addr_q <= dst_addr_d;
            dst_mask_q <= dst_mask_d;
            rdata_q <= rdata_d;
            hit_cnt_q <= hit_cnt_d;
            last_hit_q <= last_hit_d;
            res_valid_q <= res_valid_d;
            res_q <= res_d;
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_result_valid = res_valid_q;
    assign o_result = res_q;

endmodule

// [iacl_matcher_bench.sv]
// Self-checking bench for the access control entry matcher
module iacl_matcher_bench
    import iacl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, wr, rd, fv, rv;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, c, v, sa, sm, da, dm, r;
    logic [127:0] w;
    logic [15:0] hits;
    iacl_frame_t f, fr;
    iacl_result_t res;
    integer seed = 58836;
    int num_errors = 0;
    int checked = 0;
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    iacl_matcher dut_u (.i_sys_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_frame_valid(fv), .i_frame(fr),
        .o_result_valid(rv), .o_result(res));
    iacl_rx_model rx_u (.i_sys_clk(clk), .o_frame_valid(fv), .o_frame(fr));
    // ==========================================================
    // Bus cycles and comparisons
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // ==========================================================
    // Expected outcome
    function automatic logic tri_ok(input logic [1:0] s, input logic b);
        return s == 2'h1 ? !b : s == 2'h2 ? b : 1'b1;
    endfunction
    function automatic logic ad_ok(input logic [1:0] s, input logic [31:0] x, a, m);
        return s == 2'h1 ? x == a : s == 2'h2 ? ((x ^ a) & m) == 32'h0 : 1'b1;
    endfunction
    function automatic logic [7:0] pnum(input logic [2:0] p);
        case (p)
            3'h1: return v[7:0];
            3'h2: return IACL_PROTO_ICMP;
            3'h3: return IACL_PROTO_UDP;
            3'h4: return IACL_PROTO_TCP;
            default: return f.protocol;
        endcase
    endfunction
    function automatic logic [2:0] exp_res();
        logic v4;
        logic h;
        v4 = c[1:0] == 2'h1;
        h = f.is_ipv4 && f.protocol == pnum(c[4:2]) && tri_ok(c[6:5], f.ttl != 8'h00)
            && tri_ok(c[8:7], f.more_frag || f.frag_offset != 13'h0000)
            && tri_ok(c[10:9], f.options) && ad_ok(c[12:11], f.source_ipv4_address, sa, sm)
            && ad_ok(c[14:13], f.destination_ipv4_address, da, dm);
        if (c[4:2] == 3'h2) begin
            h = h && (!c[15] || f.icmp_type == v[15:8]) && (!c[16] || f.icmp_code == v[23:16]);
        end
        return {!v4 || h, v4, v4 && c[4:2] inside {3'h2, 3'h3, 3'h4}};
    endfunction
    // ==========================================================
    // Configure, send one frame, compare result and status
    task automatic run_one(input int gap);
        logic [2:0] e;
        e = exp_res();
        wr_reg(IACL_REG_CTRL, c);
        wr_reg(IACL_REG_VALS, v);
        wr_reg(IACL_REG_SRC_ADDR, sa);
        wr_reg(IACL_REG_SRC_MASK, sm);
        wr_reg(IACL_REG_DST_ADDR, da);
        wr_reg(IACL_REG_DST_MASK, dm);
        rx_u.put(f, gap);
        #1 chk({28'h0, rv, res}, {28'h1, e});
        rd_chk(IACL_REG_STATUS, {29'h0, e[0], e[1], e[2]});
        rd_chk(IACL_REG_VALS, {8'h00, v[23:0]});
        if (e[2]) hits = hits + 16'h0001;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #3000000;
        num_errors++;
        close_out();
    end
    initial begin
        {rst, wr, rd, addr, wdata} = {1'b1, 38'h0};
        {c, v, sa, sm, da, dm} = '0;
        f = '0;
        hits = 16'h0000;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_chk(IACL_REG_CTRL, 32'h0);
        wr_reg(4'hA, 32'hFFFF_FFFF);
        rd_chk(4'hA, 32'h0);
        run_one(0);
        // IPv4 entry excluding fragments, offset of one only
        c = 32'h0000_0081;
        f.is_ipv4 = 1'b1;
        f.frag_offset = 13'h0001;
        run_one(0);
        $display("test corners done");
        for (int i = 0; i < 300; i++) begin
            r = $random(seed);
            c = $random(seed) & 32'h0001_FFFF;
            c[4:2] = 3'(i % 5);
            if (r[0]) c[1:0] = 2'h1;
            {v, sa, sm, da} = {$random(seed), $random(seed), $random(seed), $random(seed)};
            dm = $random(seed);
            w = {$random(seed), $random(seed), $random(seed), $random(seed)};
            f = w[111:0];
            f.is_ipv4 = r[1] | r[2];
            if (r[3]) f.protocol = pnum(c[4:2]);
            if (r[4]) f.source_ipv4_address = sa ^ (r[5] ? 32'h0 : ~sm & w[127:96]);
            if (r[6]) f.destination_ipv4_address = da ^ (r[7] ? 32'h0 : ~dm & w[127:96]);
            if (r[8]) f.icmp_type = v[15:8];
            if (r[9]) f.icmp_code = v[23:16];
            f.ttl = r[10] ? 8'h00 : r[11] ? 8'h01 : f.ttl;
            f.more_frag = r[12] & r[13];
            f.frag_offset = r[14] ? 13'h0000 : f.frag_offset;
            f.options = r[16];
            run_one(int'(r[20:18]));
        end
        $display("test random done");
        // Readback of settings and the hit counter, then a counter preset
        rd_chk(IACL_REG_HIT_CNT, {16'h0000, hits});
        rd_chk(IACL_REG_CTRL, c);
        rd_chk(IACL_REG_SRC_ADDR, sa);
        rd_chk(IACL_REG_SRC_MASK, sm);
        rd_chk(IACL_REG_DST_ADDR, da);
        rd_chk(IACL_REG_DST_MASK, dm);
        wr_reg(IACL_REG_HIT_CNT, 32'h1234_ABCD);
        rd_chk(IACL_REG_HIT_CNT, 32'h0000_ABCD);
        $display("test registers done");
        // Mid-run reset clears settings, counter and result
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1 chk({28'h0, rv, res}, 32'h0);
        rd_chk(IACL_REG_CTRL, 32'h0);
        rd_chk(IACL_REG_HIT_CNT, 32'h0);
        $display("test reset done");
        close_out();
    end
endmodule

// [iacl_matcher_checker.sv]
// Concurrent checks on the ports of the access control entry matcher
module iacl_matcher_checker
    import iacl_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [3:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [31:0] o_reg_rdata,
    input wire logic i_frame_valid,
    input wire iacl_frame_t i_frame,
    input wire logic o_result_valid,
    input wire iacl_result_t o_result
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Shadow of control and value words
    logic [31:0] ctrl_q;
    logic [31:0] vals_q;
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            ctrl_q <= 32'h0000_0000;
            vals_q <= 32'h0000_0000;
        end else if (i_reg_wr && i_reg_addr == IACL_REG_CTRL) begin
            ctrl_q <= i_reg_wdata;
        end else if (i_reg_wr && i_reg_addr == IACL_REG_VALS) begin
            vals_q <= i_reg_wdata;
        end
    end
    // Frame checked against an IPv4 entry
    wire logic v4 = i_frame_valid && ctrl_q[1:0] == 2'h1;
    wire logic [2:0] ps = ctrl_q[4:2];
    wire logic frg = i_frame.more_frag || i_frame.frag_offset != 13'h0000;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // ==========================================================
    // Properties
    property p_hold; !i_frame_valid |=> !o_result_valid && $stable(o_result); endproperty
    a_hold: assert property (p_hold) else $error("result moved without frame");
    property p_any; i_frame_valid && ctrl_q[1:0] != 2'h1 |=> o_result.hit; endproperty
    a_any: assert property (p_any) else $error("non IPv4 entry missed");
    property p_v4; v4 && !i_frame.is_ipv4 |=> !o_result.hit; endproperty
    a_v4: assert property (p_v4) else $error("non IPv4 frame hit");
    property p_pro; v4 && ps == 3'h1 && i_frame.protocol != vals_q[7:0] |=> !o_result.hit;
    endproperty
    a_pro: assert property (p_pro) else $error("protocol value ignored");
    property p_l4;
        i_frame_valid |=> o_result.l4_enable == ($past(v4) && $past(ps) inside {3'h2, 3'h3, 3'h4});
    endproperty
    a_l4: assert property (p_l4) else $error("l4 enable wrong");
    property p_ttl; v4 && (ctrl_q[6:5] == 2'h1 && i_frame.ttl != 8'h00
        || ctrl_q[6:5] == 2'h2 && i_frame.ttl == 8'h00) |=> !o_result.hit; endproperty
    a_ttl: assert property (p_ttl) else $error("ttl setting ignored");
    property p_frg; v4 && (ctrl_q[8:7] == 2'h1 && frg || ctrl_q[8:7] == 2'h2 && !frg)
        |=> !o_result.hit; endproperty
    a_frg: assert property (p_frg) else $error("fragment setting ignored");
    property p_opt; v4 && (ctrl_q[10:9] == 2'h1 && i_frame.options
        || ctrl_q[10:9] == 2'h2 && !i_frame.options) |=> !o_result.hit; endproperty
    a_opt: assert property (p_opt) else $error("options setting ignored");
    property p_ity; v4 && ps == 3'h2 && ctrl_q[15] && i_frame.icmp_type != vals_q[15:8]
        |=> !o_result.hit; endproperty
    a_ity: assert property (p_ity) else $error("icmp type ignored");
    property p_icd; v4 && ps == 3'h2 && ctrl_q[16] && i_frame.icmp_code != vals_q[23:16]
        |=> !o_result.hit; endproperty
    a_icd: assert property (p_icd) else $error("icmp code ignored");
endmodule

bind iacl_matcher iacl_matcher_checker chk_u (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_frame_valid(i_frame_valid), .i_frame(i_frame),
    .o_result_valid(o_result_valid), .o_result(o_result));

// [iacl_pkg.sv]
// Package for the IPv4 access control entry matcher: register map, fields, types
package iacl_pkg;

    // ==========================================================
    // Register offsets (word addresses on the plain port)
    localparam logic [3:0] IACL_REG_CTRL = 4'h0;
    localparam logic [3:0] IACL_REG_VALS = 4'h1;
    localparam logic [3:0] IACL_REG_SRC_ADDR = 4'h2;
    localparam logic [3:0] IACL_REG_SRC_MASK = 4'h3;
    localparam logic [3:0] IACL_REG_DST_ADDR = 4'h4;
    localparam logic [3:0] IACL_REG_DST_MASK = 4'h5;
    localparam logic [3:0] IACL_REG_STATUS = 4'h6;
    localparam logic [3:0] IACL_REG_HIT_CNT = 4'h7;

    // ==========================================================
    // Control register field positions
    localparam int IACL_CTRL_FTYPE_LSB = 0;
    localparam int IACL_CTRL_PROTO_LSB = 2;
    localparam int IACL_CTRL_TTL_LSB = 5;
    localparam int IACL_CTRL_FRAG_LSB = 7;
    localparam int IACL_CTRL_OPT_LSB = 9;
    localparam int IACL_CTRL_SRC_LSB = 11;
    localparam int IACL_CTRL_DST_LSB = 13;
    localparam int IACL_CTRL_ITYPE_BIT = 15;
    localparam int IACL_CTRL_ICODE_BIT = 16;
    localparam int IACL_CTRL_USED = 17;

    // Value register field positions
    localparam int IACL_VALS_PROTO_LSB = 0;
    localparam int IACL_VALS_ITYPE_LSB = 8;
    localparam int IACL_VALS_ICODE_LSB = 16;

    // ==========================================================
    // Fixed protocol numbers and reset values
    localparam logic [7:0] IACL_PROTO_ICMP = 8'h01;
    localparam logic [7:0] IACL_PROTO_TCP = 8'h06;
    localparam logic [7:0] IACL_PROTO_UDP = 8'h11;
    localparam logic [31:0] IACL_RST_WORD = 32'h0000_0000;
    localparam logic [15:0] IACL_CNT_ONE = 16'h0001;

    // ==========================================================
    // Setting encodings
    typedef enum logic [1:0] {
        IACL_FT_ANY = 2'b00,
        IACL_FT_IPV4 = 2'b01,
        IACL_FT_OTHER = 2'b10
    } iacl_ftype_t;

    typedef enum logic [2:0] {
        IACL_PR_ANY = 3'b000,
        IACL_PR_SPECIFIC = 3'b001,
        IACL_PR_ICMP = 3'b010,
        IACL_PR_UDP = 3'b011,
        IACL_PR_TCP = 3'b100
    } iacl_proto_sel_t;

    // Three-way flag setting: any / zero-or-no / nonzero-or-yes
    typedef enum logic [1:0] {
        IACL_TRI_ANY = 2'b00,
        IACL_TRI_NO = 2'b01,
        IACL_TRI_YES = 2'b10
    } iacl_tri_t;

    typedef enum logic [1:0] {
        IACL_AD_ANY = 2'b00,
        IACL_AD_HOST = 2'b01,
        IACL_AD_NET = 2'b10
    } iacl_addr_sel_t;

    // Parsed header fields of one frame from the receive path
    typedef struct packed {
        logic        is_ipv4;
        logic [7:0]  protocol;
        logic [7:0]  ttl;
        logic        more_frag;
        logic [12:0] frag_offset;
        logic        options;
        logic [31:0] source_ipv4_address;
        logic [31:0] destination_ipv4_address;
        logic [7:0]  icmp_type;
        logic [7:0]  icmp_code;
    } iacl_frame_t;

    // Match result of one frame
    typedef struct packed {
        logic hit;
        logic ipv4_selected;
        logic l4_enable;
    } iacl_result_t;

endpackage

// [iacl_rx_model.sv]
// Receive path model handing parsed frames to the matcher
module iacl_rx_model
    import iacl_pkg::*;
(
    input wire logic i_sys_clk,
    output logic o_frame_valid,
    output iacl_frame_t o_frame
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_frame_valid = 1'b0;
        o_frame = '0;
    end
    // One frame after an idle gap; the idle bus is scrambled
    task automatic put(input iacl_frame_t f, input int gap);
        repeat (gap) @(posedge i_sys_clk);
        @(posedge i_sys_clk);
        o_frame_valid <= 1'b1;
        o_frame <= f;
        @(posedge i_sys_clk);
        o_frame_valid <= 1'b0;
        o_frame <= ~f;
    endtask
endmodule
